// ### verilog/smsw_pkg.sv
package smsw_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0]  STATUS_ADDR      = 4'h0;
    localparam logic [3:0]  EXC_LEVEL_ADDR   = 4'h4;
    localparam logic [3:0]  MODE_OUT_ADDR    = 4'h8;
    localparam int          ADDR_W           = 4;
    // ==========================================================
    // Status field positions
    localparam int          SWIM_HI_POS      = 9;
    localparam int          SWIM_LO_POS      = 8;
    localparam int          KX_POS           = 7;
    localparam int          SX_POS           = 6;
    localparam int          UX_POS           = 5;
    localparam int          MODE_HI_POS      = 4;
    localparam int          MODE_LO_POS      = 3;
    localparam int          EXL_POS          = 1;
    localparam int          ERL_POS          = 0;
    // ==========================================================
    // Reset values (hardware-undefined fields reset to a fixed value here)
    localparam logic [1:0]  SWIM_RST         = 2'h0;
    localparam logic [1:0]  MODE_RST         = 2'h0;
    localparam logic [1:0]  LEVEL_RST        = 2'h0;
    // ==========================================================
    // Base mode encodings
    localparam logic [1:0]  MODE_KERNEL      = 2'h0;
    localparam logic [1:0]  MODE_SUPER       = 2'h1;
    localparam logic [1:0]  MODE_USER        = 2'h2;
    localparam logic [1:0]  MODE_RSVD        = 2'h3;
    typedef enum logic [1:0] {SMSW_KERNEL, SMSW_SUPER, SMSW_USER} smsw_mode_t;
endpackage

// ### verilog/smsw_mode_dec.sv
`timescale 1ns/1ps
// ==========================================================
// Effective mode decode
module smsw_mode_dec #(
    parameter bit SUPER_IMPL = 1'b1
) (
    // Inputs
    input  wire logic [1:0]          i_base_mode_field,
    input  wire logic                i_exception_level_bit,
    input  wire logic                i_error_level_bit,
    // Outputs
    output smsw_pkg::smsw_mode_t     o_mode,
    output logic                     o_int_block
);
    import smsw_pkg::*;
    wire level_set = i_exception_level_bit | i_error_level_bit;
    wire user_base_bit = i_base_mode_field[1];
    // Reserved code 11 falls to user so an undefined write never raises privilege
    assign o_mode = level_set ? SMSW_KERNEL :
                    !SUPER_IMPL ? (user_base_bit ? SMSW_USER : SMSW_KERNEL) :
                    (i_base_mode_field == MODE_KERNEL) ? SMSW_KERNEL :
                    (i_base_mode_field == MODE_SUPER) ? SMSW_SUPER : SMSW_USER;
    assign o_int_block = level_set;
endmodule

// ### verilog/smsw_status.sv
`timescale 1ns/1ps
// Behaviour
// - Status bits 9 and 8 are read/write software-interrupt masks, 1 enabling the request.
// - In external controller mode the masks stay writable but no longer gate interrupts.
// - Bits 7, 6 and 5 read as zero, ignore writes and reset to zero.
// - With supervisor mode, bits 4:3 form a read/write base-mode field.
// - Base-mode 00 is kernel, 01 supervisor and 10 user.
// - The two-bit field and the single user bit alias the same storage.
// - Without supervisor mode, bit 4 alone selects the base mode and is read/write.
// - The single user bit at 0 means kernel and at 1 means user.
// - Exception or error level forces kernel mode and blocks all interrupts.
module smsw_status #(
    parameter bit SUPER_IMPL = 1'b1
) (
    // Clock and reset
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rst_n,
    // Wishbone slave
    input  wire logic                        i_wb_cyc,
    input  wire logic                        i_wb_stb,
    input  wire logic                        i_wb_we,
    input  wire logic [smsw_pkg::ADDR_W-1:0] i_wb_adr,
    input  wire logic [3:0]                  i_wb_sel,
    input  wire logic [31:0]                 i_wb_dat,
    output logic [31:0]                      o_wb_dat,
    output logic                             o_wb_ack,
    // Core side
    input  wire logic                        i_ext_int_ctrl_capability_flag,
    input  wire logic [1:0]                  i_soft_int_req,
    output logic [1:0]                       o_soft_int_pending,
    output logic [1:0]                       o_eff_mode,
    output logic                             o_int_block
);
    import smsw_pkg::*;

    // ==========================================================
    // Reset synchroniser
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire rst_n = rst_sync_ff;

    // ==========================================================
    // Bus decode
    logic       ack_ff;
    logic [31:0] rdat_ff;
    wire req      = i_wb_cyc & i_wb_stb & ~ack_ff;
    wire hit_stat = (i_wb_adr == STATUS_ADDR);
    wire hit_lvl  = (i_wb_adr == EXC_LEVEL_ADDR);
    wire hit_mode = (i_wb_adr == MODE_OUT_ADDR);
    wire wr_stat  = req & i_wb_we & hit_stat;
    wire wr_lvl   = req & i_wb_we & hit_lvl;
    // Fields below bit 8 sit in byte 0, masks in byte 1
    wire wr_b0    = i_wb_sel[0];
    wire wr_b1    = i_wb_sel[1];

    // ==========================================================
    // Storage
    logic [1:0] soft_interrupt_mask_ff;
    logic [1:0] base_mode_field_ff;
    logic [1:0] level_ff;
    logic [1:0] nxt_soft_interrupt_mask;
    logic [1:0] nxt_base_mode_field;
    logic [1:0] nxt_level;

    assign nxt_soft_interrupt_mask = (wr_stat & wr_b1) ?
        i_wb_dat[SWIM_HI_POS:SWIM_LO_POS] : soft_interrupt_mask_ff;
    // One storage pair; without supervisor mode the low bit is the reserved mode bit
    assign nxt_base_mode_field = !(wr_stat & wr_b0) ? base_mode_field_ff :
        SUPER_IMPL ? i_wb_dat[MODE_HI_POS:MODE_LO_POS] :
        {i_wb_dat[MODE_HI_POS], 1'b0};
    assign nxt_level = (wr_lvl & wr_b0) ?
        {i_wb_dat[EXL_POS], i_wb_dat[ERL_POS]} : level_ff;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_interrupt_mask_ff <= SWIM_RST;
            base_mode_field_ff     <= MODE_RST;
            level_ff               <= LEVEL_RST;
        end else begin
            soft_interrupt_mask_ff <= nxt_soft_interrupt_mask;
            base_mode_field_ff     <= nxt_base_mode_field;
            level_ff               <= nxt_level;
        end
    end

    // ==========================================================
    // Effective mode, registered so a change applies from the next cycle
    smsw_mode_t mode_w;
    logic       block_w;
    smsw_mode_dec #(
        .SUPER_IMPL (SUPER_IMPL)
    ) u_dec (
        .i_base_mode_field     (base_mode_field_ff),
        .i_exception_level_bit (level_ff[1]),
        .i_error_level_bit     (level_ff[0]),
        .o_mode                (mode_w),
        .o_int_block           (block_w)
    );

    wire [1:0] swint_gate = (i_ext_int_ctrl_capability_flag | block_w) ? 2'h0 :
                            soft_interrupt_mask_ff;
    wire [1:0] nxt_pending = i_soft_int_req & swint_gate;

    logic [1:0] eff_mode_ff;
    logic [1:0] pending_ff;
    logic       block_ff;
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eff_mode_ff <= MODE_KERNEL;
            pending_ff  <= 2'h0;
            block_ff    <= 1'b0;
        end else begin
            eff_mode_ff <= mode_w;
            pending_ff  <= nxt_pending;
            block_ff    <= block_w;
        end
    end
    assign o_eff_mode         = eff_mode_ff;
    assign o_soft_int_pending = pending_ff;
    assign o_int_block        = block_ff;

    // ==========================================================
    // Read data; wide-space enables are never stored and read zero
    wire [31:0] stat_word = {22'h0, soft_interrupt_mask_ff,
                             3'h0,
                             base_mode_field_ff, 3'h0};
    wire [31:0] lvl_word  = {30'h0, level_ff};
    wire [31:0] mode_word = {30'h0, eff_mode_ff};
    // Unmapped addresses still ack with zero so the bus never hangs
    wire [31:0] rd_mux = hit_stat ? stat_word :
                         hit_lvl  ? lvl_word  :
                         hit_mode ? mode_word : 32'h0;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0;
        end else begin
            ack_ff  <= req;
            rdat_ff <= req ? rd_mux : 32'h0;
        end
    end
    assign o_wb_ack = ack_ff;
    assign o_wb_dat = rdat_ff;

    // ==========================================================
    // Checks
    property p_mask_write;
        @(posedge i_core_clk) disable iff (!rst_n)
        (wr_stat & wr_b1) |=> (soft_interrupt_mask_ff == $past(i_wb_dat[9:8]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask not written");

    property p_eic_gate;
        @(posedge i_core_clk) disable iff (!rst_n)
        i_ext_int_ctrl_capability_flag |=> (o_soft_int_pending == 2'h0);
    endproperty
    a_eic_gate: assert property (p_eic_gate) else $error("mask active in eic mode");

    property p_wide_zero;
        @(posedge i_core_clk) disable iff (!rst_n)
        (o_wb_ack & hit_stat) |-> (o_wb_dat[7:5] == 3'h0);
    endproperty
    a_wide_zero: assert property (p_wide_zero) else $error("wide enables not zero");

    property p_mode_write;
        @(posedge i_core_clk) disable iff (!rst_n)
        (wr_stat & wr_b0 & SUPER_IMPL) |=> (base_mode_field_ff == $past(i_wb_dat[4:3]));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode field lost");

    sequence s_user_base;
        (level_ff == 2'h0) && (base_mode_field_ff == MODE_USER);
    endsequence
    property p_user_decode;
        @(posedge i_core_clk) disable iff (!rst_n)
        s_user_base |=> (o_eff_mode == SMSW_USER);
    endproperty
    a_user_decode: assert property (p_user_decode) else $error("user decode wrong");

    property p_alias;
        @(posedge i_core_clk) disable iff (!rst_n)
        (!SUPER_IMPL) |-> (base_mode_field_ff[0] == 1'b0);
    endproperty
    a_alias: assert property (p_alias) else $error("reserved mode bit set");

    property p_level_kernel;
        @(posedge i_core_clk) disable iff (!rst_n)
        (level_ff != 2'h0) |=> (o_eff_mode == SMSW_KERNEL) && o_int_block
                                && (o_soft_int_pending == 2'h0);
    endproperty
    a_level_kernel: assert property (p_level_kernel) else $error("level not forcing");

    property p_mode_follow;
        @(posedge i_core_clk) disable iff (!rst_n)
        (SUPER_IMPL && (level_ff == 2'h0) && (base_mode_field_ff != MODE_RSVD))
            |=> (o_eff_mode == $past(base_mode_field_ff));
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode late");

    property p_ack_one;
        @(posedge i_core_clk) disable iff (!rst_n)
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");

    // ==========================================================
    // Checks on holding, decoding and the bus answer
    property p_mask_hold;
        @(posedge i_core_clk) disable iff (!rst_n)
        !(wr_stat & wr_b1) |=> $stable(soft_interrupt_mask_ff);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask moved unwritten");

    property p_mask_off;
        @(posedge i_core_clk) disable iff (!rst_n)
        (soft_interrupt_mask_ff == 2'h0) |=> (o_soft_int_pending == 2'h0);
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked request passed");

    property p_pend_pass;
        @(posedge i_core_clk) disable iff (!rst_n)
        (!i_ext_int_ctrl_capability_flag && (level_ff == 2'h0)
            && (soft_interrupt_mask_ff == 2'h3))
            |=> (o_soft_int_pending == $past(i_soft_int_req));
    endproperty
    a_pend_pass: assert property (p_pend_pass) else $error("enabled request lost");

    property p_eic_write;
        @(posedge i_core_clk) disable iff (!rst_n)
        (i_ext_int_ctrl_capability_flag && wr_stat && wr_b1)
            |=> (soft_interrupt_mask_ff == $past(i_wb_dat[9:8]));
    endproperty
    a_eic_write: assert property (p_eic_write) else $error("mask locked in eic mode");

    property p_mode_hold;
        @(posedge i_core_clk) disable iff (!rst_n)
        !(wr_stat & wr_b0) |=> $stable(base_mode_field_ff);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved unwritten");

    property p_kernel_decode;
        @(posedge i_core_clk) disable iff (!rst_n)
        ((level_ff == 2'h0) && (base_mode_field_ff == MODE_KERNEL))
            |=> (o_eff_mode == SMSW_KERNEL);
    endproperty
    a_kernel_decode: assert property (p_kernel_decode) else $error("kernel decode");

    property p_super_decode;
        @(posedge i_core_clk) disable iff (!rst_n)
        (SUPER_IMPL && (level_ff == 2'h0) && (base_mode_field_ff == MODE_SUPER))
            |=> (o_eff_mode == SMSW_SUPER);
    endproperty
    a_super_decode: assert property (p_super_decode) else $error("super decode");

    property p_user_bit_write;
        @(posedge i_core_clk) disable iff (!rst_n)
        (!SUPER_IMPL && wr_stat && wr_b0)
            |=> (base_mode_field_ff == {$past(i_wb_dat[MODE_HI_POS]), 1'b0});
    endproperty
    a_user_bit_write: assert property (p_user_bit_write) else $error("user bit");

    property p_user_bit_set;
        @(posedge i_core_clk) disable iff (!rst_n)
        (!SUPER_IMPL && (level_ff == 2'h0) && base_mode_field_ff[1])
            |=> (o_eff_mode == SMSW_USER);
    endproperty
    a_user_bit_set: assert property (p_user_bit_set) else $error("user bit not user");

    property p_user_bit_clear;
        @(posedge i_core_clk) disable iff (!rst_n)
        (!SUPER_IMPL && (level_ff == 2'h0) && !base_mode_field_ff[1])
            |=> (o_eff_mode == SMSW_KERNEL);
    endproperty
    a_user_bit_clear: assert property (p_user_bit_clear) else $error("user bit clear");

    property p_level_write;
        @(posedge i_core_clk) disable iff (!rst_n)
        (wr_lvl & wr_b0) |=> (level_ff == $past(i_wb_dat[1:0]));
    endproperty
    a_level_write: assert property (p_level_write) else $error("level not written");

    property p_block_clear;
        @(posedge i_core_clk) disable iff (!rst_n)
        (level_ff == 2'h0) |=> !o_int_block;
    endproperty
    a_block_clear: assert property (p_block_clear) else $error("block without level");

    // A take must give one ack and then drop it, so a master never sees a double
    sequence s_bus_take;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_ack_pulse;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    property p_ack_answer;
        @(posedge i_core_clk) disable iff (!rst_n)
        s_bus_take |=> s_ack_pulse;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack not a single pulse");

    property p_dat_idle;
        @(posedge i_core_clk) disable iff (!rst_n)
        !o_wb_ack |-> (o_wb_dat == 32'h0);
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");

    property p_unmapped_zero;
        @(posedge i_core_clk) disable iff (!rst_n)
        (o_wb_ack && !hit_stat && !hit_lvl && !hit_mode) |-> (o_wb_dat == 32'h0);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
endmodule

// ### sim/status_mode_and_swint_mask_tb_top.sv
`timescale 1ns/1ps
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin err_total++; \
    $display("BAD %0t value mismatch", $time); end end
// ==========================================================
// Bench for the status register block
module status_mode_and_swint_mask_tb_top;
    import smsw_pkg::*;
    logic        i_core_clk = 1'b0;
    logic        i_rst_n    = 1'b0;
    logic        i_wb_cyc   = 1'b0;
    logic        i_wb_stb   = 1'b0;
    logic        i_wb_we    = 1'b0;
    logic [3:0]  i_wb_adr   = 4'h0;
    logic [3:0]  i_wb_sel   = 4'h0;
    logic [31:0] i_wb_dat   = 32'h0;
    logic        i_flag     = 1'b0;
    logic [1:0]  i_req      = 2'h0;
    logic [31:0] o_wb_dat;
    logic        o_wb_ack;
    logic [1:0]  o_pend;
    logic [1:0]  o_eff_mode;
    logic        o_int_block;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic [31:0] o2_wb_dat;
    logic [1:0]  o2_eff_mode;
    int          err_total    = 0;
    int          total_checks = 0;
    always #12.5 i_core_clk = ~i_core_clk;
    smsw_status #(.SUPER_IMPL(1'b1)) dut_u (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
        .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .i_ext_int_ctrl_capability_flag(i_flag),
        .i_soft_int_req(i_req), .o_soft_int_pending(o_pend),
        .o_eff_mode(o_eff_mode), .o_int_block(o_int_block));
    // Copy without supervisor mode shares the bus, so it sees every write
    smsw_status #(.SUPER_IMPL(1'b0)) dut_um_u (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
        .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o2_wb_dat),
        .o_wb_ack(), .i_ext_int_ctrl_capability_flag(i_flag),
        .i_soft_int_req(i_req), .o_soft_int_pending(),
        .o_eff_mode(o2_eff_mode), .o_int_block());
    // ==========================================================
    // Bus cycles: no fixed latency assumed, only the bound of the loop
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] sel, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= we;
        i_wb_adr <= a;
        i_wb_dat <= d;
        i_wb_sel <= sel;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 10);
        q = o_wb_dat;
        rd2 = o2_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we  <= 1'b0;
        if (n >= 10) begin
            err_total++;
            $display("BAD %0t no ack", $time);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF, rd);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hF, rd);
        `CHK(rd, e)
    endtask
    // Outputs lag a register change by one cycle; three edges leave margin
    task automatic settle();
        repeat (3) @(posedge i_core_clk);
        #1;
    endtask
    task automatic end_sim();
        $display("Total compares %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rdchk(STATUS_ADDR, 32'h0);
        rdchk(MODE_OUT_ADDR, 32'h0);
        `CHK(o_eff_mode, MODE_KERNEL)
        $display("reset test done");
    endtask
    task automatic t_mask();
        wr(STATUS_ADDR, 32'h3E0);
        rdchk(STATUS_ADDR, 32'h300);
        @(posedge i_core_clk);
        i_req <= 2'h3;
        settle();
        `CHK(o_pend, 2'h3)
        wr(STATUS_ADDR, 32'h100);
        settle();
        `CHK(o_pend, 2'h1)
        wb(1'b1, STATUS_ADDR, 32'h308, 4'h1, rd);
        rdchk(STATUS_ADDR, 32'h108);
        $display("mask test done");
    endtask
    task automatic t_mode();
        logic [1:0] codes [3] = '{MODE_KERNEL, MODE_SUPER, MODE_USER};
        // Code 11 is never written by software
        for (int i = 0; i < 3; i++) begin
            wr(STATUS_ADDR, 32'(codes[i]) << MODE_LO_POS);
            rdchk(STATUS_ADDR, 32'(codes[i]) << MODE_LO_POS);
            rdchk(MODE_OUT_ADDR, 32'(codes[i]));
            settle();
            `CHK(o_eff_mode, codes[i])
        end
        $display("mode test done");
    endtask
    task automatic t_level();
        wr(STATUS_ADDR, 32'h310);
        for (int lv = 1; lv < 3; lv++) begin
            wr(EXC_LEVEL_ADDR, 32'(lv));
            settle();
            `CHK(o_eff_mode, MODE_KERNEL)
            `CHK({o_int_block, o_pend}, 3'h4)
        end
        wr(EXC_LEVEL_ADDR, 32'h0);
        settle();
        `CHK({o_int_block, o_eff_mode, o_pend}, 5'h0B)
        rdchk(STATUS_ADDR, 32'h310);
        $display("level test done");
    endtask
    task automatic t_eic();
        @(posedge i_core_clk);
        i_flag <= 1'b1;
        wr(STATUS_ADDR, 32'h200);
        rdchk(STATUS_ADDR, 32'h200);
        settle();
        `CHK(o_pend, 2'h0)
        @(posedge i_core_clk);
        i_flag <= 1'b0;
        settle();
        `CHK(o_pend, 2'h2)
        wr(4'hC, 32'hFFFFFFFF);
        rdchk(4'hC, 32'h0);
        rdchk(STATUS_ADDR, 32'h200);
        $display("external mode test done");
    endtask
    // Code 11 must stay off the shared bus, so only 10 and 01 are used here
    task automatic t_nosup();
        wr(STATUS_ADDR, 32'h10);
        rdchk(STATUS_ADDR, 32'h10);
        `CHK(rd2, 32'h10)
        settle();
        `CHK(o2_eff_mode, MODE_USER)
        wr(STATUS_ADDR, 32'h08);
        rdchk(STATUS_ADDR, 32'h08);
        `CHK(rd2, 32'h0)
        settle();
        `CHK({o_eff_mode, o2_eff_mode}, {MODE_SUPER, MODE_KERNEL})
        $display("user bit test done");
    endtask
    task automatic t_rerst();
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        `CHK(o_pend, 2'h0)
        `CHK(o_eff_mode, MODE_KERNEL)
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        rdchk(STATUS_ADDR, 32'h0);
        `CHK(rd2, 32'h0)
        rdchk(EXC_LEVEL_ADDR, 32'h0);
        $display("mid-run reset test done");
    endtask
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        t_reset();
        t_mask();
        t_mode();
        t_level();
        t_eic();
        t_nosup();
        t_rerst();
        end_sim();
    end
    initial begin
        repeat (3000) @(posedge i_core_clk);
        err_total++;
        $display("BAD %0t timeout", $time);
        end_sim();
    end
endmodule
